// ==== logic/pglo_pkg.sv ====
// package with register map, reset values and carrier types for the port block
package pglo_pkg;
    localparam int ADDR_W = 4;
    // register indices, the request address is the index itself
    localparam logic [3:0] IDX_A_LATCH = 4'h0;
    localparam logic [3:0] IDX_A_DIR = 4'h1;
    localparam logic [3:0] IDX_A_PIN = 4'h2;
    localparam logic [3:0] IDX_B_LATCH = 4'h3;
    localparam logic [3:0] IDX_B_DIR = 4'h4;
    localparam logic [3:0] IDX_B_PIN = 4'h5;
    localparam logic [3:0] IDX_C_LATCH = 4'h6;
    localparam logic [3:0] IDX_C_DIR = 4'h7;
    localparam logic [3:0] IDX_C_PIN = 4'h8;
    localparam logic [3:0] IDX_G_LATCH = 4'h9;
    localparam logic [3:0] IDX_G_DIR = 4'ha;
    localparam logic [3:0] IDX_G_PIN = 4'hb;
    localparam logic [3:0] IDX_LCD_CTRL = 4'hc;
    // lcd control register fields
    localparam int LCD_EN_POS = 4;
    localparam int LCD_PM_LSB = 0;
    localparam int LCD_PM_W = 4;
    // reset values
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] LCD_CTRL_RST = 8'h00;
    // mask thresholds for port g takeover
    localparam logic [3:0] PM_THR_BIT4 = 4'h5;
    localparam logic [3:0] PM_THR_BIT3 = 4'h6;
    localparam logic [3:0] PM_THR_BIT10 = 4'h0;
    localparam int PG_W = 5;

    // override bundle for one pin
    typedef struct packed {
        logic pullup_override_enable;
        logic pullup_override_value;
        logic direction_override_enable;
        logic direction_override_value;
        logic port_value_override_enable;
        logic port_value_override_value;
        logic input_enable_override_enable;
        logic input_enable_override_value;
    } pglo_ovr_t;

    // register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pglo_req_t;
endpackage

// ==== logic/pglo_pin.sv ====
// one port pin: applies overrides to the latch, direction and pull-up paths
`timescale 1ns/1ps
module pglo_pin (
    input wire logic latch,
    input wire logic dir,
    input wire logic pullup_disable,
    input wire pglo_pkg::pglo_ovr_t ovr,
    output logic pin_out,
    output logic pin_oe_n,
    output logic pullup_on,
    output logic input_en
);
    logic dir_eff;
    // override muxes, plain port logic when an enable is low
    always_comb
    begin
        dir_eff = ovr.direction_override_enable ? ovr.direction_override_value : dir;
        pin_out = ovr.port_value_override_enable ? ovr.port_value_override_value : latch;
        pin_oe_n = ~dir_eff;
        pullup_on = ovr.pullup_override_enable ? ovr.pullup_override_value
                                               : (~dir & latch & ~pullup_disable);
        input_en = ovr.input_enable_override_enable ? ovr.input_enable_override_value : 1'b1;
    end
endmodule

// ==== logic/pglo_top.sv ====
// port registers and port g lcd and counter-source override logic
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// ==========================================
module pglo_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire pglo_pkg::pglo_req_t req,
    output logic [7:0] rdata,
    input wire logic pullup_disable,
    input wire logic [7:0] pa_in,
    input wire logic [7:0] pb_in,
    input wire logic [7:0] pc_in,
    input wire logic [4:0] pg_in,
    input wire logic [4:0] segment_drive,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe_n,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe_n,
    output logic [7:0] pc_out,
    output logic [7:0] pc_oe_n,
    output logic [4:0] pg_out,
    output logic [4:0] pg_oe_n,
    output logic [4:0] pg_pullup_on,
    output logic [4:0] pg_input_en,
    output logic [4:0] pg_analog_pin_path,
    output logic counter0_external_source,
    output logic counter1_external_source
);
    // ==========================================
    // registers
    logic [7:0] a_latch_q, a_dir_q, b_latch_q, b_dir_q, c_latch_q, c_dir_q;
    logic [4:0] g_latch_q, g_dir_q;
    logic [7:0] lcd_ctrl_q;
    logic [7:0] a_s1_q, a_s2_q, b_s1_q, b_s2_q, c_s1_q, c_s2_q;
    logic [4:0] g_s1_q, g_s2_q;
    logic lcd_driver_enable;
    logic [3:0] lcd_port_mask;
    logic [4:0] g_in_eff;
    logic [4:0] g_out_c, g_oe_n_c, g_pu_c, g_ie_c;
    logic [4:0] seg_c;
    pglo_pkg::pglo_ovr_t ovr [pglo_pkg::PG_W];

    assign lcd_driver_enable = lcd_ctrl_q[pglo_pkg::LCD_EN_POS];
    assign lcd_port_mask = lcd_ctrl_q[pglo_pkg::LCD_PM_LSB +: pglo_pkg::LCD_PM_W];

    // ==========================================
    // register writes
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            a_latch_q <= pglo_pkg::LATCH_RST;
            b_latch_q <= pglo_pkg::LATCH_RST;
            c_latch_q <= pglo_pkg::LATCH_RST;
            g_latch_q <= pglo_pkg::LATCH_RST[4:0];
            a_dir_q <= pglo_pkg::DIR_RST;
            b_dir_q <= pglo_pkg::DIR_RST;
            c_dir_q <= pglo_pkg::DIR_RST;
            g_dir_q <= pglo_pkg::DIR_RST[4:0];
            lcd_ctrl_q <= pglo_pkg::LCD_CTRL_RST;
        end
        else if (ce && req.wr)
        begin
            if (req.addr == pglo_pkg::IDX_A_LATCH)
                a_latch_q <= req.wdata;
            else if (req.addr == pglo_pkg::IDX_A_DIR)
                a_dir_q <= req.wdata;
            else if (req.addr == pglo_pkg::IDX_B_LATCH)
                b_latch_q <= req.wdata;
            else if (req.addr == pglo_pkg::IDX_B_DIR)
                b_dir_q <= req.wdata;
            else if (req.addr == pglo_pkg::IDX_C_LATCH)
                c_latch_q <= req.wdata;
            else if (req.addr == pglo_pkg::IDX_C_DIR)
                c_dir_q <= req.wdata;
            else if (req.addr == pglo_pkg::IDX_G_LATCH)
                g_latch_q <= req.wdata[4:0];
            else if (req.addr == pglo_pkg::IDX_G_DIR)
                g_dir_q <= req.wdata[4:0];
            else if (req.addr == pglo_pkg::IDX_LCD_CTRL)
                lcd_ctrl_q <= {3'h0, req.wdata[4:0]};
        end
    end

    // ==========================================
    // pin synchronisers, no reset since content follows the pins
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            a_s1_q <= pa_in;
            a_s2_q <= a_s1_q;
            b_s1_q <= pb_in;
            b_s2_q <= b_s1_q;
            c_s1_q <= pc_in;
            c_s2_q <= c_s1_q;
            g_s1_q <= pg_in;
            g_s2_q <= g_s1_q;
        end
    end

    // ==========================================
    // read data, one cycle after the strobe, zero otherwise while ce is high, held while ce is low
    // port g pin reads are gated by the input enable, so a taken-over pin reads zero
    always_ff @(posedge clk)
    begin
        if (!nrst)
            rdata <= 8'h00;
        else if (ce)
        begin
            if (!req.rd)
                rdata <= 8'h00;
            else if (req.addr == pglo_pkg::IDX_A_LATCH)
                rdata <= a_latch_q;
            else if (req.addr == pglo_pkg::IDX_A_DIR)
                rdata <= a_dir_q;
            else if (req.addr == pglo_pkg::IDX_A_PIN)
                rdata <= a_s2_q;
            else if (req.addr == pglo_pkg::IDX_B_LATCH)
                rdata <= b_latch_q;
            else if (req.addr == pglo_pkg::IDX_B_DIR)
                rdata <= b_dir_q;
            else if (req.addr == pglo_pkg::IDX_B_PIN)
                rdata <= b_s2_q;
            else if (req.addr == pglo_pkg::IDX_C_LATCH)
                rdata <= c_latch_q;
            else if (req.addr == pglo_pkg::IDX_C_DIR)
                rdata <= c_dir_q;
            else if (req.addr == pglo_pkg::IDX_C_PIN)
                rdata <= c_s2_q;
            else if (req.addr == pglo_pkg::IDX_G_LATCH)
                rdata <= {3'h0, g_latch_q};
            else if (req.addr == pglo_pkg::IDX_G_DIR)
                rdata <= {3'h0, g_dir_q};
            else if (req.addr == pglo_pkg::IDX_G_PIN)
                rdata <= {3'h0, g_in_eff};
            else if (req.addr == pglo_pkg::IDX_LCD_CTRL)
                rdata <= lcd_ctrl_q;
            else
                rdata <= 8'h00;
        end
    end

    // ==========================================
    // port g override decode from lcd enable and mask
    always_comb
    begin
        seg_c[4] = lcd_driver_enable && (lcd_port_mask > pglo_pkg::PM_THR_BIT4);
        seg_c[3] = lcd_driver_enable && (lcd_port_mask > pglo_pkg::PM_THR_BIT3);
        seg_c[2] = lcd_driver_enable;
        seg_c[1] = lcd_driver_enable && (lcd_port_mask > pglo_pkg::PM_THR_BIT10);
        seg_c[0] = lcd_driver_enable && (lcd_port_mask > pglo_pkg::PM_THR_BIT10);
    end

    // ==========================================
    // per-pin override bundles and pin logic
    genvar gi;
    generate
        for (gi = 0; gi < pglo_pkg::PG_W; gi++)
        begin : g_pin
            always_comb
            begin
                ovr[gi].pullup_override_enable = seg_c[gi];
                ovr[gi].pullup_override_value = 1'b0;
                ovr[gi].direction_override_enable = seg_c[gi];
                ovr[gi].direction_override_value = (gi == 4);
                ovr[gi].port_value_override_enable = 1'b0;
                ovr[gi].port_value_override_value = 1'b0;
                ovr[gi].input_enable_override_enable = seg_c[gi];
                ovr[gi].input_enable_override_value = 1'b0;
            end
            pglo_pin u_pin (
                .latch(g_latch_q[gi]),
                .dir(g_dir_q[gi]),
                .pullup_disable(pullup_disable),
                .ovr(ovr[gi]),
                .pin_out(g_out_c[gi]),
                .pin_oe_n(g_oe_n_c[gi]),
                .pullup_on(g_pu_c[gi]),
                .input_en(g_ie_c[gi])
            );
            assign g_in_eff[gi] = g_s2_q[gi] & g_ie_c[gi];
        end
    endgenerate

    // ==========================================
    // registered pin and counter-source outputs
    // registering every output keeps the pads glitch free while overrides change
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pa_out <= 8'h00;
            pa_oe_n <= 8'hff;
            pb_out <= 8'h00;
            pb_oe_n <= 8'hff;
            pc_out <= 8'h00;
            pc_oe_n <= 8'hff;
            pg_out <= 5'h00;
            pg_oe_n <= 5'h1f;
            pg_pullup_on <= 5'h00;
            pg_input_en <= 5'h1f;
            pg_analog_pin_path <= 5'h00;
            counter0_external_source <= 1'b0;
            counter1_external_source <= 1'b0;
        end
        else if (ce)
        begin
            pa_out <= a_latch_q;
            pa_oe_n <= ~a_dir_q;
            pb_out <= b_latch_q;
            pb_oe_n <= ~b_dir_q;
            pc_out <= c_latch_q;
            pc_oe_n <= ~c_dir_q;
            pg_out <= g_out_c;
            pg_oe_n <= g_oe_n_c;
            pg_pullup_on <= g_pu_c;
            pg_input_en <= g_ie_c;
            pg_analog_pin_path <= seg_c & segment_drive;
            counter0_external_source <= g_in_eff[4];
            counter1_external_source <= g_in_eff[3];
        end
    end

    // ==========================================
    // checks
    // a port a latch write accepted on a running clock
    sequence s_latch_wr;
        ce && req.wr && req.addr == pglo_pkg::IDX_A_LATCH;
    endsequence
    // takeover of bit 4 requested on a running clock
    sequence s_take4;
        ce && lcd_driver_enable && lcd_port_mask > pglo_pkg::PM_THR_BIT4;
    endsequence
    // takeover of bit 3 requested on a running clock
    sequence s_take3;
        ce && lcd_driver_enable && lcd_port_mask > pglo_pkg::PM_THR_BIT3;
    endsequence

    a_line23_takeover: assert property (@(posedge clk) disable iff (!nrst)
        ce && lcd_driver_enable && lcd_port_mask > 4'h5 |=> !pg_pullup_on[4] && !pg_oe_n[4] && !pg_input_en[4])
        else $error("bit 4 segment takeover wrong");
    a_line24_takeover: assert property (@(posedge clk) disable iff (!nrst)
        ce && lcd_driver_enable && lcd_port_mask > 4'h6 |=> !pg_pullup_on[3] && pg_oe_n[3] && !pg_input_en[3])
        else $error("bit 3 segment takeover wrong");
    a_line4_always: assert property (@(posedge clk) disable iff (!nrst)
        ce && lcd_driver_enable |=> !pg_input_en[2] && pg_oe_n[2])
        else $error("bit 2 not taken over");
    a_line13_mask: assert property (@(posedge clk) disable iff (!nrst)
        ce && lcd_driver_enable && lcd_port_mask != 4'h0 |=> !pg_input_en[1])
        else $error("bit 1 not taken over");
    a_line14_mask: assert property (@(posedge clk) disable iff (!nrst)
        ce && lcd_driver_enable && lcd_port_mask != 4'h0 |=> !pg_input_en[0] && !pg_pullup_on[0])
        else $error("bit 0 not taken over");
    a_plain_mode: assert property (@(posedge clk) disable iff (!nrst)
        ce && !lcd_driver_enable |=> pg_input_en == 5'h1f && pg_out == $past(g_latch_q))
        else $error("plain port path not followed");
    a_count0_src: assert property (@(posedge clk) disable iff (!nrst)
        ce && g_ie_c[4] |=> counter0_external_source == $past(g_s2_q[4]))
        else $error("counter0 source wrong");
    a_count1_src: assert property (@(posedge clk) disable iff (!nrst)
        ce && g_ie_c[3] |=> counter1_external_source == $past(g_s2_q[3]))
        else $error("counter1 source wrong");
    a_latch_write: assert property (@(posedge clk) disable iff (!nrst)
        s_latch_wr ##1 ce |=> pa_out == $past(req.wdata, 2))
        else $error("latch write not seen on pins");
    a_dir_readback: assert property (@(posedge clk) disable iff (!nrst)
        ce && req.rd && req.addr == pglo_pkg::IDX_B_DIR |=> rdata == $past(b_dir_q))
        else $error("direction readback wrong");

    // ==========================================
    // takeover side effects on the counter sources and the other bits
    a_take4_count: assert property (@(posedge clk) disable iff (!nrst)
        s_take4 |=> !counter0_external_source)
        else $error("bit 4 takeover left counter0 input open");
    a_take3_count: assert property (@(posedge clk) disable iff (!nrst)
        s_take3 |=> !counter1_external_source)
        else $error("bit 3 takeover left counter1 input open");
    a_take10_dir: assert property (@(posedge clk) disable iff (!nrst)
        ce && lcd_driver_enable && lcd_port_mask > pglo_pkg::PM_THR_BIT10
        |=> pg_oe_n[1:0] == 2'h3 && pg_pullup_on[1:0] == 2'h0)
        else $error("bits 1 and 0 override values wrong");
    a_ovr_pullup: assert property (@(posedge clk) disable iff (!nrst)
        ce && lcd_driver_enable |=> !pg_pullup_on[2])
        else $error("bit 2 pull-up not forced off");
    a_line4_link: assert property (@(posedge clk) disable iff (!nrst)
        ce && lcd_driver_enable |=> pg_analog_pin_path[2] == $past(segment_drive[2]))
        else $error("bit 2 segment link wrong");
    a_port_value: assert property (@(posedge clk) disable iff (!nrst)
        ce |=> pg_out == $past(g_latch_q))
        else $error("port value overridden");

    // ==========================================
    // plain port paths while overrides are idle
    a_free4_plain: assert property (@(posedge clk) disable iff (!nrst)
        ce && !(lcd_driver_enable && lcd_port_mask > pglo_pkg::PM_THR_BIT4)
        |=> pg_input_en[4] && pg_oe_n[4] == !$past(g_dir_q[4]))
        else $error("bit 4 plain path not followed");
    a_free3_plain: assert property (@(posedge clk) disable iff (!nrst)
        ce && !(lcd_driver_enable && lcd_port_mask > pglo_pkg::PM_THR_BIT3)
        |=> pg_input_en[3] && pg_oe_n[3] == !$past(g_dir_q[3]))
        else $error("bit 3 plain path not followed");
    a_free10_plain: assert property (@(posedge clk) disable iff (!nrst)
        ce && !(lcd_driver_enable && lcd_port_mask > pglo_pkg::PM_THR_BIT10) |=> pg_input_en[1:0] == 2'h3)
        else $error("bits 1 and 0 plain input path not followed");
    a_seg_idle: assert property (@(posedge clk) disable iff (!nrst)
        ce && !lcd_driver_enable |=> pg_analog_pin_path == 5'h00)
        else $error("segment linked while lcd is off");
    a_pullup_off: assert property (@(posedge clk) disable iff (!nrst)
        ce && !lcd_driver_enable && pullup_disable |=> pg_pullup_on == 5'h00)
        else $error("pull-up on while globally disabled");

    // ==========================================
    // register, pin and clock-enable behaviour of the plain ports
    a_latch_pins: assert property (@(posedge clk) disable iff (!nrst)
        ce |=> pb_out == $past(b_latch_q) && pc_out == $past(c_latch_q))
        else $error("latch not driven to pins");
    a_dir_pins: assert property (@(posedge clk) disable iff (!nrst)
        ce |=> pa_oe_n == ~$past(a_dir_q) && pb_oe_n == ~$past(b_dir_q)
            && pc_oe_n == ~$past(c_dir_q))
        else $error("direction not driven to pins");
    a_pin_read: assert property (@(posedge clk) disable iff (!nrst)
        ce && req.rd && req.addr == pglo_pkg::IDX_A_PIN |=> rdata == $past(a_s2_q))
        else $error("pin register read wrong");
    a_ce_freeze: assert property (@(posedge clk) disable iff (!nrst)
        !ce |=> $stable(a_latch_q) && $stable(a_dir_q)
            && $stable(pa_out) && $stable(rdata))
        else $error("state moved with clock enable low");
    a_reset_vals: assert property (@(posedge clk)
        !nrst |=> a_latch_q == pglo_pkg::LATCH_RST && a_dir_q == pglo_pkg::DIR_RST
            && pa_oe_n == 8'hff && pb_oe_n == 8'hff && pc_oe_n == 8'hff)
        else $error("reset values not taken");
endmodule

// ==== sim/pglo_pins.sv ====
// pin-side model: resolves every pad from the block's drivers and outside levels, port g pads also from pull-ups
`timescale 1ns/1ps
module pglo_pins (
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pa_oe_n,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pb_oe_n,
    input wire logic [7:0] pc_out,
    input wire logic [7:0] pc_oe_n,
    input wire logic [4:0] pg_out,
    input wire logic [4:0] pg_oe_n,
    input wire logic [4:0] pg_pullup_on,
    input wire logic [7:0] ext_a,
    input wire logic [7:0] ext_b,
    input wire logic [7:0] ext_c,
    input wire logic [4:0] ext_g,
    output logic [7:0] pa_in,
    output logic [7:0] pb_in,
    output logic [7:0] pc_in,
    output logic [4:0] pg_in
);
    // ==========================================
    // pad resolution
    // a driven pad shows the block's level, a released one the outside level
    assign pa_in = (~pa_oe_n & pa_out) | (pa_oe_n & ext_a);
    assign pb_in = (~pb_oe_n & pb_out) | (pb_oe_n & ext_b);
    assign pc_in = (~pc_oe_n & pc_out) | (pc_oe_n & ext_c);
    // a released port g pad with its pull-up on is held high
    assign pg_in = (~pg_oe_n & pg_out) | (pg_oe_n & (pg_pullup_on | ext_g));
endmodule

// ==== sim/tb_pglo_top.sv ====
// self-checking testbench for the port registers and port g override logic
`timescale 1ns/1ps
module tb_pglo_top;
    logic clk, nrst, ce, pullup_disable;
    pglo_pkg::pglo_req_t req;
    logic [7:0] rdata, pa_in, pb_in, pc_in, pa_out, pa_oe_n, pb_out, pb_oe_n, pc_out, pc_oe_n;
    logic [7:0] ext_a, ext_b, ext_c, v;
    logic [4:0] pg_in, segment_drive, pg_out, pg_oe_n, pg_pullup_on, pg_input_en, pg_analog_pin_path;
    logic [4:0] ext_g, take;
    logic counter0_external_source, counter1_external_source;
    int n_fail, comparisons, cycles;

    pglo_top u_pglo_top (.clk(clk), .nrst(nrst), .ce(ce), .req(req), .rdata(rdata),
        .pullup_disable(pullup_disable), .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in), .pg_in(pg_in),
        .segment_drive(segment_drive), .pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_out(pb_out),
        .pb_oe_n(pb_oe_n), .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pg_out(pg_out), .pg_oe_n(pg_oe_n),
        .pg_pullup_on(pg_pullup_on), .pg_input_en(pg_input_en), .pg_analog_pin_path(pg_analog_pin_path),
        .counter0_external_source(counter0_external_source),
        .counter1_external_source(counter1_external_source));
    pglo_pins u_pglo_pins (.pa_out(pa_out), .pa_oe_n(pa_oe_n), .pb_out(pb_out), .pb_oe_n(pb_oe_n),
        .pc_out(pc_out), .pc_oe_n(pc_oe_n), .pg_out(pg_out), .pg_oe_n(pg_oe_n), .pg_pullup_on(pg_pullup_on),
        .ext_a(ext_a), .ext_b(ext_b), .ext_c(ext_c), .ext_g(ext_g), .pa_in(pa_in), .pb_in(pb_in),
        .pc_in(pc_in), .pg_in(pg_in));

    // ==========================================
    // clock, time-zero values and hang guard
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        nrst = 1'b0; ce = 1'b1; pullup_disable = 1'b0; req = '0; segment_drive = 5'h1f;
        ext_a = 8'h3c; ext_b = 8'hc3; ext_c = 8'h96; ext_g = 5'h1f;
        n_fail = 0; comparisons = 0; cycles = 0;
    end
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end

    // ==========================================
    // access and compare tasks
    task automatic wr_reg(input logic [3:0] idx, input logic [7:0] d);
        @(posedge clk);
        req.addr <= idx; req.wdata <= d; req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] idx, output logic [7:0] d);
        @(posedge clk);
        req.addr <= idx; req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons = comparisons + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================
    // test sequence
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        // reset values of latches and directions, pins released
        for (int i = 0; i < 6; i++)
        begin
            rd_reg(4'(i / 2 * 3 + i % 2), v);
            chk(v, 8'h00, "reset value");
        end
        chk(pa_oe_n & pb_oe_n & pc_oe_n, 8'hff, "pins start as inputs");
        $display("test reset done");
        // pin registers follow the pads and ignore writes
        wr_reg(pglo_pkg::IDX_A_PIN, 8'hff);
        settle(3);
        rd_reg(pglo_pkg::IDX_A_PIN, v);
        chk(v, 8'h3c, "port a pin level");
        rd_reg(pglo_pkg::IDX_C_PIN, v);
        chk(v, 8'h96, "port c pin level");
        rd_reg(4'hd, v);
        chk(v, 8'h00, "unmapped read");
        $display("test pin levels done");
        // latch and direction write, read back and reach the pads
        for (int p = 0; p < 3; p++)
        begin
            wr_reg(4'(p * 3), 8'ha5 + 8'(p));
            wr_reg(4'(p * 3 + 1), 8'h5a);
        end
        for (int p = 0; p < 3; p++)
        begin
            rd_reg(4'(p * 3), v);
            chk(v, 8'ha5 + 8'(p), "latch read back");
            rd_reg(4'(p * 3 + 1), v);
            chk(v, 8'h5a, "direction read back");
        end
        chk(pa_out, 8'ha5, "port a out");
        chk(pc_out, 8'ha7, "port c out");
        chk(pb_oe_n, 8'ha5, "port b drivers");
        rd_reg(pglo_pkg::IDX_B_PIN, v);
        chk(v, 8'ha6 & 8'h5a | 8'hc3 & 8'ha5, "port b mixed pads");
        $display("test latch and direction done");
        // every lcd enable and mask value against the takeover table
        wr_reg(pglo_pkg::IDX_G_LATCH, 8'h1f);
        wr_reg(pglo_pkg::IDX_G_DIR, 8'h00);
        for (int k = 0; k < 32; k++)
        begin
            wr_reg(pglo_pkg::IDX_LCD_CTRL, 8'(k));
            segment_drive <= 5'(k * 3);
            settle(4);
            take = k[4] ? {k[3:0] > 5, k[3:0] > 6, 1'b1, k[3:0] > 0, k[3:0] > 0} : 5'h00;
            chk({3'h0, pg_pullup_on}, {3'h0, ~take}, "pull-up");
            chk({3'h0, pg_oe_n}, {3'h0, ~(take & 5'h10)}, "direction");
            chk({3'h0, pg_input_en}, {3'h0, ~take}, "input enable");
            chk({3'h0, pg_out}, 8'h1f, "port value");
            chk({3'h0, pg_analog_pin_path}, {3'h0, take & 5'(k * 3)}, "segment link");
            chk({7'h0, counter0_external_source}, {7'h0, ~take[4]}, "counter0 source");
            chk({7'h0, counter1_external_source}, {7'h0, ~take[3]}, "counter1 source");
            rd_reg(pglo_pkg::IDX_G_PIN, v);
            chk(v, {3'h0, ~take}, "port g pin level");
        end
        $display("test lcd takeover done");
        // global pull-up disable with overrides idle
        wr_reg(pglo_pkg::IDX_LCD_CTRL, 8'h0f);
        pullup_disable <= 1'b1;
        ext_g <= 5'h0a;
        settle(4);
        chk({3'h0, pg_pullup_on}, 8'h00, "pull-up disabled");
        chk({7'h0, counter0_external_source}, 8'h00, "counter0 follows low pad");
        chk({7'h0, counter1_external_source}, 8'h01, "counter1 follows high pad");
        rd_reg(pglo_pkg::IDX_G_PIN, v);
        chk(v, 8'h0a, "port g outside level");
        $display("test pull-up disable done");
        // clock enable low: a write is ignored and the latch holds
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(pglo_pkg::IDX_A_LATCH, 8'h11);
        ce <= 1'b1;
        rd_reg(pglo_pkg::IDX_A_LATCH, v);
        chk(v, 8'ha5, "latch frozen by clock enable");
        chk(pa_out, 8'ha5, "pins frozen by clock enable");
        $display("test clock enable done");
        // reset in mid-run returns latches and directions to zero
        @(posedge clk);
        nrst <= 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(pglo_pkg::IDX_A_LATCH, v);
        chk(v, 8'h00, "latch after second reset");
        rd_reg(pglo_pkg::IDX_C_DIR, v);
        chk(v, 8'h00, "direction after second reset");
        chk(pa_out | ~pc_oe_n, 8'h00, "pins after second reset");
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
